// >>> hdl/spd_pkg.sv
package spd_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NUM_PORT = 2;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  // ------------------------------------------------------------
  // Channel numbering: bit 0 is direction, bit 1 is port
  // ------------------------------------------------------------
  localparam int CH_DIR_BIT = 0;
  localparam int CH_PORT_BIT = 1;

  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PTR_RESET = 32'h00000000;
  localparam logic [ADDR_W-1:0] PTR_STEP = 32'h00000001;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_EMPTY = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SPD_IDLE = 3'h1,
    SPD_BUS = 3'h2,
    SPD_SETTLE = 3'h4
  } spd_fsm_t;

  typedef struct packed {
    logic ptr_we;
    logic cnt_we;
    logic [ADDR_W-1:0] wdata;
  } spd_sw_wr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } spd_mem_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] ptr;
    logic [CNT_W-1:0] cnt;
    logic done;
  } spd_chan_state_t;

  typedef struct packed {
    spd_fsm_t fsm;
    logic [CH_W-1:0] ch;
    spd_mem_req_t mem;
    logic [NUM_PORT-1:0] rx_take;
    logic [NUM_PORT-1:0] tx_load;
    logic [NUM_PORT-1:0][BYTE_W-1:0] tx_data;
    logic [NUM_CH-1:0] advance;
  } spd_top_state_t;

endpackage : spd_pkg

// >>> hdl/spd_chan.sv
`timescale 1ns/10ps
`default_nettype none
module spd_chan
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software writes decoded by the owning serial port
  input wire logic load_ptr,
  input wire logic load_cnt,
  input wire logic [ADDR_W-1:0] wr_data,
  // Byte moved
  input wire logic advance,
  // State
  output logic [ADDR_W-1:0] ptr,
  output logic [CNT_W-1:0] cnt,
  output logic done
);

  spd_chan_state_t st;
  spd_chan_state_t next_st;

  // ------------------------------------------------------------
  // Pointer and count
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (advance) begin
      next_st.ptr = st.ptr + PTR_STEP;
      next_st.cnt = st.cnt - CNT_STEP;
      next_st.done = (st.cnt == CNT_LAST);
    end
    if (load_ptr) begin
      next_st.ptr = wr_data;
    end
    if (load_cnt) begin
      next_st.cnt = wr_data[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ptr: PTR_RESET, cnt: CNT_RESET, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ptr = st.ptr;
  assign cnt = st.cnt;
  assign done = st.done;

endmodule : spd_chan
`default_nettype wire

// >>> hdl/spd_top.sv
// How it works
// - four channels, receive and transmit per port
// - each channel holds pointer and count
// - count exhausted flags end of transfer
// - one program covers up to 65535 bytes
// - bytes move without processor help
// - registers written through owning port's decode
`timescale 1ns/10ps
`default_nettype none
module spd_top
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // Register writes from the serial ports
  input wire spd_sw_wr_t [NUM_CH-1:0] SW_WR,
  // Channel state back to the serial ports
  output logic [NUM_CH-1:0][ADDR_W-1:0] CH_PTR,
  output logic [NUM_CH-1:0][CNT_W-1:0] CH_CNT,
  output logic [NUM_CH-1:0] END_XFER,
  // Serial port receive side
  input wire logic [NUM_PORT-1:0] RX_FULL,
  input wire logic [NUM_PORT-1:0][BYTE_W-1:0] RX_DATA,
  output logic [NUM_PORT-1:0] RX_TAKE,
  // Serial port transmit side
  input wire logic [NUM_PORT-1:0] TX_EMPTY,
  output logic [NUM_PORT-1:0] TX_LOAD,
  output logic [NUM_PORT-1:0][BYTE_W-1:0] TX_DATA,
  // Memory bus
  output spd_mem_req_t MEM,
  input wire logic MEM_ACK,
  input wire logic [BYTE_W-1:0] MEM_RDATA
);

  spd_top_state_t st;
  spd_top_state_t next_st;
  logic [NUM_CH-1:0] eligible;
  logic [NUM_CH-1:0] done;
  logic [NUM_CH-1:0][ADDR_W-1:0] ptr;
  logic [NUM_CH-1:0][CNT_W-1:0] cnt;

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [CH_W-1:0] CH_ID = gi[CH_W-1:0];
      localparam int PORT = CH_ID[CH_PORT_BIT];

      spd_chan u_chan (
        .clk(REF_CLK),
        .rst_n(NRST),
        .load_ptr(SW_WR[gi].ptr_we),
        .load_cnt(SW_WR[gi].cnt_we),
        .wr_data(SW_WR[gi].wdata),
        .advance(st.advance[gi]),
        .ptr(ptr[gi]),
        .cnt(cnt[gi]),
        .done(done[gi])
      );

      // Even channel receives, odd channel transmits
      if (CH_ID[CH_DIR_BIT] == 1'b0) begin : g_rx
        assign eligible[gi] = (cnt[gi] != CNT_EMPTY) && RX_FULL[PORT];
      end else begin : g_tx
        assign eligible[gi] = (cnt[gi] != CNT_EMPTY) && TX_EMPTY[PORT];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic [CH_W-1:0] sel;
    logic found;
    logic port;
    sel = '0;
    found = 1'b0;
    port = 1'b0;
    next_st = st;
    next_st.rx_take = '0;
    next_st.tx_load = '0;
    next_st.advance = '0;
    // Lowest numbered ready channel wins
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel = i[CH_W-1:0];
        found = 1'b1;
      end
    end
    case (st.fsm)
      SPD_IDLE: begin
        port = sel[CH_PORT_BIT];
        if (found) begin
          next_st.ch = sel;
          next_st.mem.req = 1'b1;
          next_st.mem.addr = ptr[sel];
          if (sel[CH_DIR_BIT] == 1'b0) begin
            next_st.rx_take[port] = 1'b1;
            next_st.mem.we = 1'b1;
            next_st.mem.wdata = RX_DATA[port];
          end else begin
            next_st.mem.we = 1'b0;
            next_st.mem.wdata = BYTE_RESET;
          end
          next_st.fsm = SPD_BUS;
        end
      end
      SPD_BUS: begin
        port = st.ch[CH_PORT_BIT];
        if (MEM_ACK) begin
          next_st.mem.req = 1'b0;
          next_st.mem.we = 1'b0;
          if (st.ch[CH_DIR_BIT] == 1'b1) begin
            next_st.tx_load[port] = 1'b1;
            next_st.tx_data[port] = MEM_RDATA;
          end
          next_st.advance[st.ch] = 1'b1;
          next_st.fsm = SPD_SETTLE;
        end
      end
      SPD_SETTLE: begin
        // Lets the port flags and the count catch up
        next_st.fsm = SPD_IDLE;
      end
      default: begin
        next_st.fsm = SPD_IDLE;
        next_st.mem.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st.fsm <= SPD_IDLE;
      st.ch <= '0;
      st.mem <= '{req: 1'b0, we: 1'b0, addr: PTR_RESET, wdata: BYTE_RESET};
      st.rx_take <= '0;
      st.tx_load <= '0;
      st.tx_data <= '0;
      st.advance <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign CH_PTR = ptr;
  assign CH_CNT = cnt;
  assign END_XFER = done;
  assign RX_TAKE = st.rx_take;
  assign TX_LOAD = st.tx_load;
  assign TX_DATA = st.tx_data;
  assign MEM = st.mem;

endmodule : spd_top
`default_nettype wire

// >>> bench/spd_chk.sv
`timescale 1ns/10ps
`default_nettype none
module spd_chk
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // Channels
  input wire spd_sw_wr_t [NUM_CH-1:0] SW_WR,
  input wire logic [NUM_CH-1:0][ADDR_W-1:0] CH_PTR,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] CH_CNT,
  input wire logic [NUM_CH-1:0] END_XFER,
  // Ports and memory
  input wire logic [NUM_PORT-1:0] RX_FULL,
  input wire logic [NUM_PORT-1:0] RX_TAKE,
  input wire logic [NUM_PORT-1:0] TX_LOAD,
  input wire logic [NUM_PORT-1:0][BYTE_W-1:0] TX_DATA,
  input wire spd_mem_req_t MEM,
  input wire logic MEM_ACK,
  input wire logic [BYTE_W-1:0] MEM_RDATA
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  sequence ack_ch0;
    MEM.req && MEM_ACK && MEM.addr == CH_PTR[0] && !SW_WR[0].cnt_we;
  endsequence
  req_hold_a:
    assert property (MEM.req && !MEM_ACK |=> MEM.req && $stable(MEM.addr)) else $error("request dropped");
  take_rx_a:
    assert property (RX_TAKE[0] |-> MEM.req && MEM.we && MEM.addr == CH_PTR[0]) else $error("bad rx start");
  take_paced_a:
    assert property (RX_TAKE[1] |-> $past(RX_FULL[1]) && !$past(RX_TAKE[1])) else $error("unpaced take");
  load_data_a:
    assert property (TX_LOAD[1] |-> $past(MEM_ACK) && TX_DATA[1] == $past(MEM_RDATA)) else $error("bad tx byte");
  cnt_write_a:
    assert property (SW_WR[1].cnt_we |=> CH_CNT[1] == $past(SW_WR[1].wdata[CNT_W-1:0])) else $error("cnt write");
  ptr_write_a:
    assert property (SW_WR[2].ptr_we |=> CH_PTR[2] == $past(SW_WR[2].wdata)) else $error("ptr write");
  end_xfer_a:
    assert property (END_XFER[0] |-> CH_CNT[0] == 16'h0000 && $past(CH_CNT[0]) == 16'h0001) else $error("bad end");
  step_a:
    assert property (ack_ch0 |-> ##2 CH_CNT[0] == $past(CH_CNT[0], 2) - 16'h0001
      && CH_PTR[0] == $past(CH_PTR[0], 2) + 32'h00000001) else $error("bad step");
endmodule : spd_chk
bind spd_top spd_chk u_chk (
  .REF_CLK(REF_CLK), .NRST(NRST), .SW_WR(SW_WR), .CH_PTR(CH_PTR), .CH_CNT(CH_CNT), .END_XFER(END_XFER),
  .RX_FULL(RX_FULL), .RX_TAKE(RX_TAKE), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA),
  .MEM(MEM), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
);
`default_nettype wire

// >>> bench/spd_far.sv
`timescale 1ns/10ps
`default_nettype none
module spd_far
  import spd_pkg::*;
(
  // Clock and test controls
  input wire logic clk,
  input wire logic [NUM_PORT-1:0] fill,
  input wire logic [1:0] wt,
  // Device side
  input wire logic [NUM_PORT-1:0] RX_TAKE,
  input wire logic [NUM_PORT-1:0] TX_LOAD,
  input wire spd_mem_req_t MEM,
  output logic [NUM_PORT-1:0] RX_FULL = '0,
  output logic [NUM_PORT-1:0][BYTE_W-1:0] RX_DATA,
  output logic [NUM_PORT-1:0] TX_EMPTY = '1,
  output logic MEM_ACK = 1'b0,
  output logic [BYTE_W-1:0] MEM_RDATA = 8'h00
);
  logic [BYTE_W-1:0] mem [256];
  logic [NUM_PORT-1:0][BYTE_W-1:0] nxt = {8'hA0, 8'h50};
  logic [1:0] n = 2'h0;
  logic hit;
  assign hit = MEM.req && !MEM_ACK && n >= wt;
  always_comb begin
    for (int p = 0; p < NUM_PORT; p++) begin
      RX_DATA[p] = RX_FULL[p] ? nxt[p] : ~nxt[p];
    end
  end
  always @(posedge clk) begin
    for (int p = 0; p < NUM_PORT; p++) begin
      if (RX_TAKE[p]) begin
        RX_FULL[p] <= 1'b0;
        nxt[p] <= nxt[p] + 8'h01;
      end else if (fill[p]) begin
        RX_FULL[p] <= 1'b1;
      end
      TX_EMPTY[p] <= !TX_LOAD[p];
    end
    n <= (MEM.req && !MEM_ACK) ? n + 2'h1 : 2'h0;
    MEM_ACK <= hit;
    MEM_RDATA <= hit ? mem[MEM.addr[7:0]] : ~MEM_RDATA;
    if (hit && MEM.we) begin
      mem[MEM.addr[7:0]] <= MEM.wdata;
    end
  end
endmodule : spd_far
`default_nettype wire

// >>> bench/test_spd_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_spd_top
  import spd_pkg::*;
;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  spd_sw_wr_t [NUM_CH-1:0] SW_WR = '0;
  logic [NUM_CH-1:0][ADDR_W-1:0] CH_PTR;
  logic [NUM_CH-1:0][CNT_W-1:0] CH_CNT;
  logic [NUM_CH-1:0] END_XFER;
  logic [NUM_PORT-1:0] RX_FULL, RX_TAKE, TX_EMPTY, TX_LOAD;
  logic [NUM_PORT-1:0][BYTE_W-1:0] RX_DATA, TX_DATA;
  spd_mem_req_t MEM;
  logic MEM_ACK;
  logic [BYTE_W-1:0] MEM_RDATA;
  logic [NUM_PORT-1:0] fill = '0;
  logic [1:0] wt = 2'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  spd_top dut (
    .REF_CLK(REF_CLK), .NRST(NRST), .SW_WR(SW_WR), .CH_PTR(CH_PTR), .CH_CNT(CH_CNT), .END_XFER(END_XFER),
    .RX_FULL(RX_FULL), .RX_DATA(RX_DATA), .RX_TAKE(RX_TAKE), .TX_EMPTY(TX_EMPTY), .TX_LOAD(TX_LOAD),
    .TX_DATA(TX_DATA), .MEM(MEM), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
  );
  spd_far far (
    .clk(REF_CLK), .fill(fill), .wt(wt), .RX_TAKE(RX_TAKE), .TX_LOAD(TX_LOAD), .MEM(MEM),
    .RX_FULL(RX_FULL), .RX_DATA(RX_DATA), .TX_EMPTY(TX_EMPTY), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA)
  );
  initial forever #4 REF_CLK = !REF_CLK;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input int c, input logic p, input logic [31:0] d);
    SW_WR[c] = '{p, !p, d};
    @(negedge REF_CLK);
    SW_WR[c] = '0;
  endtask : wr
  task results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task t_regs;
    for (int c = 0; c < NUM_CH; c++) begin
      wr(c, 1'b1, 32'h10 + 32'h100 * c);
      chk(CH_PTR[c], 32'h10 + 32'h100 * c);
    end
    wr(1, 1'b0, 32'hABCD0000);
    chk(CH_CNT[1], 32'h0);
    $display("regs done");
  endtask : t_regs
  task t_rx;
    wr(0, 1'b0, 32'h2);
    fill = 2'b01;
    repeat (60) if (!END_XFER[0]) @(negedge REF_CLK);
    chk(END_XFER[0], 1'b1);
    chk(CH_PTR[0], 32'h12);
    chk(far.mem[8'h10], 8'h50);
    chk(far.mem[8'h11], 8'h51);
    repeat (8) @(negedge REF_CLK);
    chk(RX_FULL[0], 1'b1);
    fill = 2'b00;
    $display("rx done");
  endtask : t_rx
  task t_tx;
    wt = 2'h3;
    wr(3, 1'b0, 32'h2);
    for (int i = 0; i < 2; i++) begin
      repeat (60) if (!TX_LOAD[1]) @(negedge REF_CLK);
      chk(TX_DATA[1], 32'h50 + i);
      @(negedge REF_CLK);
    end
    chk(END_XFER[3], 1'b1);
    chk(CH_PTR[3], 32'h312);
    $display("tx done");
  endtask : t_tx
  task t_big;
    wt = 2'h0;
    wr(2, 1'b0, 32'hFFFF);
    chk(CH_CNT[2], 32'hFFFF);
    fill = 2'b10;
    repeat (60) if (!RX_TAKE[1]) @(negedge REF_CLK);
    fill = 2'b00;
    repeat (20) if (CH_CNT[2] == 16'hFFFF) @(negedge REF_CLK);
    chk(CH_CNT[2], 32'hFFFE);
    chk(CH_PTR[2], 32'h211);
    chk(far.mem[8'h10], 8'hA0);
    $display("big done");
  endtask : t_big
  task t_tx0;
    wr(1, 1'b0, 32'hABCD0001);
    chk(CH_CNT[1], 32'h1);
    repeat (60) if (!TX_LOAD[0]) @(negedge REF_CLK);
    chk(TX_DATA[0], 32'hA0);
    @(negedge REF_CLK);
    chk(TX_LOAD[0], 1'b0);
    chk(END_XFER[1], 1'b1);
    chk(CH_PTR[1], 32'h111);
    $display("tx0 done");
  endtask : t_tx0
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge REF_CLK);
    NRST = 1'b1;
    @(negedge REF_CLK);
    t_regs();
    t_rx();
    t_tx();
    t_big();
    t_tx0();
    results();
  end
endmodule : test_spd_top
`default_nettype wire
